// ---- include/pump_pkg.sv ----
package pump_pkg;
  // ----------------------------------------
  // Clock and time base
  // ----------------------------------------
  localparam longint CLK_HZ = 25_000_000;
  localparam longint SEC_PER_MIN = 60;
  localparam int CNT_W = 36;
  localparam longint DLY_BASE_MIN = 1;
  localparam longint DLY_MID_MIN = 10;
  localparam longint DLY_LONG_MIN = 30;
  localparam longint OC_HOLD_MIN = 3;
  localparam longint SCREEN_STEP_SEC = 2;
  localparam logic [CNT_W-1:0] DLY_BASE_CYC = CNT_W'(DLY_BASE_MIN * SEC_PER_MIN * CLK_HZ);
  localparam logic [CNT_W-1:0] DLY_MID_CYC = CNT_W'(DLY_MID_MIN * SEC_PER_MIN * CLK_HZ);
  localparam logic [CNT_W-1:0] DLY_LONG_CYC = CNT_W'(DLY_LONG_MIN * SEC_PER_MIN * CLK_HZ);
  localparam logic [CNT_W-1:0] OC_HOLD_CYC = CNT_W'(OC_HOLD_MIN * SEC_PER_MIN * CLK_HZ);
  localparam logic [CNT_W-1:0] SCREEN_STEP_CYC = CNT_W'(SCREEN_STEP_SEC * CLK_HZ);
  // ----------------------------------------
  // Switch bank and synchronised pin vector
  // ----------------------------------------
  localparam int DIP_REMOTE_INV = 0;
  localparam int DIP_WATER_INV = 1;
  localparam int DIP_DLY_MID = 2;
  localparam int DIP_DLY_LONG = 3;
  localparam int DIP_FREEZE = 6;
  localparam int SYN_W = 13;
  localparam int SYN_REMOTE = 8;
  localparam int SYN_WATER = 9;
  localparam int SYN_OC = 10;
  localparam int SYN_FRONT = 11;
  localparam int SYN_POWER = 12;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_SCREEN = 8'h08;
  localparam int CTRL_RUN_EN = 0;
  localparam logic CTRL_RUN_EN_RST = 1'b1;
  localparam int ST_MOTOR = 0;
  localparam int ST_PERMIT = 1;
  localparam int ST_OC = 2;
  localparam int ST_SPLASH = 3;
  localparam int ST_REMOTE_OK = 4;
  localparam int ST_WATER_OK = 5;
  localparam int ST_DIP_LSB = 8;
  // ----------------------------------------
  // Display and states
  // ----------------------------------------
  localparam logic [2:0] SCREEN_LAST = 3'h4;
  localparam logic [2:0] SCREEN_SPLASH = 3'h5;
  localparam logic [2:0] SCREEN_OC = 3'h6;
  localparam logic [2:0] BOOT_CYC = 3'h4;
  typedef enum logic [2:0] {
    PERMIT_BLOCKED = 3'b001,
    PERMIT_DELAY = 3'b010,
    PERMIT_GRANTED = 3'b100
  } permit_e;
  typedef enum logic [1:0] {
    OC_NORMAL = 2'b01,
    OC_TRIPPED = 2'b10
  } oc_e;
endpackage

// ---- rtl/input_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module input_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;
  sync_s st_ff;
  sync_s nxt_st;
  // Only the second stage is visible; the first may be metastable
  always_comb
  begin
    nxt_st.meta = async_in;
    nxt_st.stable = st_ff.meta;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign sync_out = st_ff.stable;
endmodule
`default_nettype wire

// ---- rtl/interval_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module interval_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [pump_pkg::CNT_W-1:0] load_val,
  output logic done
);
  import pump_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] count;
  } tmr_s;
  tmr_s st_ff;
  tmr_s nxt_st;
  // Load wins over counting so a held load keeps the full interval
  always_comb
  begin
    nxt_st = st_ff;
    if (load)
      nxt_st.count = load_val;
    else if (st_ff.count != '0)
      nxt_st.count = st_ff.count - CNT_W'(1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign done = (st_ff.count == '0);
endmodule
`default_nettype wire

// ---- rtl/pump_run_permit_control.sv ----
// Overview of operation
// [R1] Switch 1 off: remote short stops pump
// [R2] Switch 1 on: remote short required to run
// [R3] Switch 2 selects water probe polarity
// [R4] After water stop, clear then full delay
// [R5] One shared restart delay, one minute default
// [R6] Switch 3 sets ten minute delay
// [R7] Switch 4 sets thirty minute delay
// [R8] Switch 7 off: display steps at rate
// [R9] Switch 7 on: display holds current screen
// [R10] Switches 5, 6, 8 left off
// [R11] All switches off before wiring
// [R12] Over-current stops motor at once
// [R13] Over-current hold three minutes, then restart
// [R14] Over-current lights error lamp and message
// [R15] Repeated over-current repeats hold cycle
// [R16] Power lamp lit while input power good
// [R17] Switch 7 at power-up: splash only
// [R18] Halt lamp while remote/water blocks running
// [R19] Drive needs front switch, permits, no hold
// [R20] Switches 3 and 4 both: thirty minutes
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pump_run_permit_control #(
  parameter logic [pump_pkg::CNT_W-1:0] DLY_BASE_CYC_P = pump_pkg::DLY_BASE_CYC,
  parameter logic [pump_pkg::CNT_W-1:0] DLY_MID_CYC_P = pump_pkg::DLY_MID_CYC,
  parameter logic [pump_pkg::CNT_W-1:0] DLY_LONG_CYC_P = pump_pkg::DLY_LONG_CYC,
  parameter logic [pump_pkg::CNT_W-1:0] OC_HOLD_CYC_P = pump_pkg::OC_HOLD_CYC,
  parameter logic [pump_pkg::CNT_W-1:0] SCREEN_STEP_CYC_P = pump_pkg::SCREEN_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pump_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic remote_sense_terminal,
  input wire logic water_probe_terminal,
  input wire logic overcurrent_det,
  input wire logic front_switch_on,
  input wire logic power_in_ok,
  input wire logic [7:0] dip_switch,
  output logic motor_drive,
  output logic power_lamp,
  output logic run_lamp,
  output logic remote_halt_lamp,
  output logic error_lamp,
  output logic [2:0] screen_sel
);
  import pump_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    permit_e permit;
    oc_e oc;
    logic run_en;
    logic [2:0] boot_cnt;
    logic boot_done;
    logic splash_lock;
    logic [2:0] screen_idx;
    logic motor;
    logic power_lamp;
    logic halt_lamp;
    logic error_lamp;
    logic [2:0] screen_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctl_s;

  localparam ctl_s CTL_RST = '{
    permit: PERMIT_BLOCKED,
    oc: OC_NORMAL,
    run_en: CTRL_RUN_EN_RST,
    boot_cnt: 3'h0,
    boot_done: 1'b0,
    splash_lock: 1'b0,
    screen_idx: 3'h0,
    motor: 1'b0,
    power_lamp: 1'b0,
    halt_lamp: 1'b1,
    error_lamp: 1'b0,
    screen_sel: SCREEN_SPLASH,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  ctl_s st_ff;
  ctl_s nxt_st;
  logic [SYN_W-1:0] syn;
  logic [7:0] dip;
  logic remote_shorted;
  logic water_shorted;
  logic remote_ok;
  logic water_ok;
  logic cond_ok;
  logic oc_now;
  logic freeze;
  logic [CNT_W-1:0] dly_val;
  logic dly_load;
  logic dly_done;
  logic oc_load;
  logic oc_done;
  logic scr_done;
  logic apb_access;
  logic apb_commit;
  logic [31:0] status_word;

  // ----------------------------------------
  // Pin synchronisers and timers
  // ----------------------------------------
  // Contacts and switches are asynchronous to pclk
  input_sync #(
    .W(SYN_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({power_in_ok, front_switch_on, overcurrent_det,
               water_probe_terminal, remote_sense_terminal, dip_switch}),
    .sync_out(syn)
  );

  // One restart timer shared by the remote and water paths
  interval_timer u_dly (
    .pclk(pclk),
    .presetn(presetn),
    .load(dly_load),
    .load_val(dly_val),
    .done(dly_done)
  );

  interval_timer u_oc (
    .pclk(pclk),
    .presetn(presetn),
    .load(oc_load),
    .load_val(OC_HOLD_CYC_P),
    .done(oc_done)
  );

  // Reloads itself on each expiry, so it ticks once per step
  interval_timer u_scr (
    .pclk(pclk),
    .presetn(presetn),
    .load(scr_done),
    .load_val(SCREEN_STEP_CYC_P),
    .done(scr_done)
  );

  // ----------------------------------------
  // Permit decode
  // ----------------------------------------
  // Terminals are pulled up, so a contact to ground reads low.
  // Switch bank bits 4, 5 and 7 are not decoded; they only appear in the status word.
  assign dip = syn[7:0]; // [R10]
  assign remote_shorted = !syn[SYN_REMOTE];
  assign water_shorted = !syn[SYN_WATER];
  assign remote_ok = dip[DIP_REMOTE_INV] ? remote_shorted : !remote_shorted; // [R1] [R2]
  assign water_ok = dip[DIP_WATER_INV] ? water_shorted : !water_shorted; // [R3]
  assign cond_ok = remote_ok && water_ok;
  assign oc_now = syn[SYN_OC];
  assign freeze = dip[DIP_FREEZE];

  // Longest selection wins when both delay switches are on
  always_comb
  begin
    if (dip[DIP_DLY_LONG])
      dly_val = DLY_LONG_CYC_P; // [R7] [R20]
    else if (dip[DIP_DLY_MID])
      dly_val = DLY_MID_CYC_P; // [R6]
    else
      dly_val = DLY_BASE_CYC_P; // [R5]
  end

  // Timers stay reloaded until their wait actually starts
  assign dly_load = (st_ff.permit == PERMIT_BLOCKED);
  assign oc_load = (st_ff.oc == OC_NORMAL);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Answer one cycle into the access phase; writes land on the
  // completing edge only
  assign apb_access = psel && penable && !st_ff.pready;
  assign apb_commit = psel && penable && st_ff.pready;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_MOTOR] = st_ff.motor;
    status_word[ST_PERMIT] = (st_ff.permit == PERMIT_GRANTED);
    status_word[ST_OC] = (st_ff.oc == OC_TRIPPED);
    status_word[ST_SPLASH] = st_ff.splash_lock;
    status_word[ST_REMOTE_OK] = remote_ok;
    status_word[ST_WATER_OK] = water_ok;
    status_word[ST_DIP_LSB +: 8] = dip;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;

    // Restart permit: a block always restarts the full delay
    unique case (st_ff.permit)
      PERMIT_BLOCKED:
      begin
        if (cond_ok)
          nxt_st.permit = PERMIT_DELAY;
      end
      PERMIT_DELAY:
      begin
        if (!cond_ok)
          nxt_st.permit = PERMIT_BLOCKED; // [R1] [R2] [R3]
        else if (dly_done)
          nxt_st.permit = PERMIT_GRANTED; // [R4] [R5]
      end
      PERMIT_GRANTED:
      begin
        if (!cond_ok)
          nxt_st.permit = PERMIT_BLOCKED; // [R1] [R2] [R3]
      end
      default:
      begin
        nxt_st.permit = PERMIT_BLOCKED;
      end
    endcase

    // Over-current hold, retried for as long as the fault persists
    unique case (st_ff.oc)
      OC_NORMAL:
      begin
        if (oc_now)
          nxt_st.oc = OC_TRIPPED; // [R12]
      end
      OC_TRIPPED:
      begin
        if (oc_done)
          nxt_st.oc = OC_NORMAL; // [R13] [R15]
      end
      default:
      begin
        nxt_st.oc = OC_TRIPPED;
      end
    endcase

    // Start-up capture of the freeze switch, after the sync latency
    if (!st_ff.boot_done)
    begin
      if (st_ff.boot_cnt == BOOT_CYC)
      begin
        nxt_st.boot_done = 1'b1;
        nxt_st.splash_lock = freeze; // [R17]
      end
      else
        nxt_st.boot_cnt = st_ff.boot_cnt + 3'h1;
    end
    else if (!freeze)
      nxt_st.splash_lock = 1'b0; // [R17]

    // Screen stepping, halted while frozen or locked on splash
    if (scr_done && !freeze && !st_ff.splash_lock && st_ff.boot_done)
    begin
      if (st_ff.screen_idx == SCREEN_LAST)
        nxt_st.screen_idx = 3'h0; // [R8]
      else
        nxt_st.screen_idx = st_ff.screen_idx + 3'h1; // [R8]
    end

    // Outputs; the live fault term cuts the drive on the next edge
    nxt_st.motor = syn[SYN_FRONT] && st_ff.run_en && !oc_now
      && (nxt_st.permit == PERMIT_GRANTED) && (nxt_st.oc == OC_NORMAL); // [R19] [R12]
    nxt_st.power_lamp = syn[SYN_POWER]; // [R16]
    nxt_st.halt_lamp = (nxt_st.permit != PERMIT_GRANTED); // [R18]
    nxt_st.error_lamp = (nxt_st.oc == OC_TRIPPED); // [R14]
    if (nxt_st.oc == OC_TRIPPED)
      nxt_st.screen_sel = SCREEN_OC; // [R14]
    else if (nxt_st.splash_lock || !nxt_st.boot_done)
      nxt_st.screen_sel = SCREEN_SPLASH; // [R17]
    else
      nxt_st.screen_sel = nxt_st.screen_idx; // [R9]

    // Bus answer
    nxt_st.pready = apb_access;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata = 32'h0000_0000;
    if (apb_access)
    begin
      unique case (paddr)
        REG_CTRL:
          nxt_st.prdata[CTRL_RUN_EN] = st_ff.run_en;
        REG_STATUS:
          nxt_st.prdata = status_word;
        REG_SCREEN:
          nxt_st.prdata[2:0] = st_ff.screen_sel;
        default:
          nxt_st.pslverr = 1'b1;
      endcase
    end
    if (apb_commit && pwrite && (paddr == REG_CTRL))
      nxt_st.run_en = pwdata[CTRL_RUN_EN];
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= CTL_RST;
    else
      st_ff <= nxt_st;
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign motor_drive = st_ff.motor;
  assign run_lamp = st_ff.motor;
  assign power_lamp = st_ff.power_lamp;
  assign remote_halt_lamp = st_ff.halt_lamp;
  assign error_lamp = st_ff.error_lamp;
  assign screen_sel = st_ff.screen_sel;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_block_stops_run: assert property ( // [R1]
    !cond_ok |=> (st_ff.permit == PERMIT_BLOCKED) && !motor_drive)
    else $error("permit kept while remote or water blocks");

  a_delay_before_grant: assert property ( // [R4]
    (st_ff.permit == PERMIT_DELAY) && cond_ok && !dly_done |=> st_ff.permit == PERMIT_DELAY)
    else $error("permit granted before delay expired");

  a_base_delay: assert property ( // [R5]
    !dip[DIP_DLY_MID] && !dip[DIP_DLY_LONG] |-> dly_val == DLY_BASE_CYC_P)
    else $error("wrong default restart delay");

  a_mid_delay: assert property ( // [R6]
    dip[DIP_DLY_MID] && !dip[DIP_DLY_LONG] |-> dly_val == DLY_MID_CYC_P)
    else $error("wrong ten minute delay");

  a_long_delay: assert property ( // [R7]
    dip[DIP_DLY_LONG] |-> dly_val == DLY_LONG_CYC_P)
    else $error("wrong thirty minute delay");

  a_oc_cuts_motor: assert property ( // [R12]
    (st_ff.oc == OC_NORMAL) && oc_now |=> !motor_drive && error_lamp)
    else $error("motor not cut on over-current");

  a_oc_hold_stays: assert property ( // [R13]
    (st_ff.oc == OC_TRIPPED) && !oc_done |=> (st_ff.oc == OC_TRIPPED) && !motor_drive)
    else $error("over-current hold left early");

  a_oc_retry: assert property ( // [R15]
    (st_ff.oc == OC_TRIPPED) && oc_done ##1 oc_now |=> st_ff.oc == OC_TRIPPED)
    else $error("persisting fault not tripped again");

  a_oc_indicate: assert property ( // [R14]
    st_ff.oc == OC_TRIPPED |-> error_lamp && (screen_sel == SCREEN_OC))
    else $error("over-current not shown");

  a_freeze_holds: assert property ( // [R9]
    freeze |=> $stable(st_ff.screen_idx))
    else $error("screen moved while frozen");

  a_screen_steps: assert property ( // [R8]
    scr_done && !freeze && !st_ff.splash_lock && st_ff.boot_done
      |=> st_ff.screen_idx != $past(st_ff.screen_idx))
    else $error("screen did not step");

  a_splash_only: assert property ( // [R17]
    st_ff.splash_lock && (st_ff.oc == OC_NORMAL) |-> screen_sel == SCREEN_SPLASH)
    else $error("splash lock not shown");

  a_halt_lamp: assert property ( // [R18]
    remote_halt_lamp == (st_ff.permit != PERMIT_GRANTED))
    else $error("halt lamp disagrees with permit");

  a_drive_needs_all: assert property ( // [R19]
    motor_drive |-> $past(syn[SYN_FRONT]) && $past(st_ff.run_en)
      && (st_ff.permit == PERMIT_GRANTED) && (st_ff.oc == OC_NORMAL))
    else $error("motor driven without permit");

  a_power_lamp: assert property ( // [R16]
    $rose(syn[SYN_POWER]) |=> power_lamp)
    else $error("power lamp not lit");

  a_bus_answer: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle");

  c_oc_trip: cover property (st_ff.oc == OC_NORMAL ##1 st_ff.oc == OC_TRIPPED);
  c_grant: cover property (st_ff.permit == PERMIT_DELAY ##1 st_ff.permit == PERMIT_GRANTED);
  c_splash: cover property (st_ff.splash_lock ##1 !st_ff.splash_lock);
  c_ctrl_write: cover property (apb_commit && pwrite && (paddr == REG_CTRL));
endmodule
`default_nettype wire

// ---- tb/contact_switch_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module contact_switch_model (
  input wire logic closed,
  output logic terminal
);
  // ----------------------------------------
  // Dry contact to ground
  // ----------------------------------------
  // A closed contact pulls the terminal to ground; an open one leaves the pull-up in charge
  assign terminal = closed ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- tb/pump_run_permit_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module pump_run_permit_control_tb;
  import pump_pkg::*;
  // ----------------------------------------
  // Shortened counts so the run stays small
  // ----------------------------------------
  localparam logic [CNT_W-1:0] BASE = 36'h14;
  localparam logic [CNT_W-1:0] MID = 36'h28;
  localparam logic [CNT_W-1:0] LONG = 36'h3c;
  localparam logic [CNT_W-1:0] OCH = 36'h1e;
  localparam logic [CNT_W-1:0] STEP = 36'h8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e, remote_closed, water_closed, remote_sense_terminal, water_probe_terminal;
  logic overcurrent_det, front_switch_on, power_in_ok, motor_drive, power_lamp, run_lamp;
  logic remote_halt_lamp, error_lamp;
  logic [7:0] dip_switch;
  logic [2:0] screen_sel, s;
  int error_cnt, samples_checked, n;
  logic [7:0] dips [5] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0c};
  logic [CNT_W-1:0] dlys [5] = '{BASE, BASE, MID, LONG, LONG};

  contact_switch_model remote_sw (.closed(remote_closed), .terminal(remote_sense_terminal));
  contact_switch_model water_sw (.closed(water_closed), .terminal(water_probe_terminal));

  pump_run_permit_control #(.DLY_BASE_CYC_P(BASE), .DLY_MID_CYC_P(MID), .DLY_LONG_CYC_P(LONG),
    .OC_HOLD_CYC_P(OCH), .SCREEN_STEP_CYC_P(STEP)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_sense_terminal(remote_sense_terminal), .water_probe_terminal(water_probe_terminal),
    .overcurrent_det(overcurrent_det), .front_switch_on(front_switch_on),
    .power_in_ok(power_in_ok), .dip_switch(dip_switch), .motor_drive(motor_drive),
    .power_lamp(power_lamp), .run_lamp(run_lamp), .remote_halt_lamp(remote_halt_lamp),
    .error_lamp(error_lamp), .screen_sel(screen_sel));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  function logic pick(input int sel);
    case (sel)
      0: pick = motor_drive;
      default: pick = error_lamp;
    endcase
  endfunction

  // Bounded wait so a stuck output cannot hang the run
  task wait_sig(input int sel, input logic v, output int k);
    k = 0;
    while (pick(sel) !== v && k < 400)
    begin
      @(posedge pclk);
      k++;
    end
    // A wait that runs out is a failure in its own right
    if (k >= 400)
      error_cnt++;
  endtask

  // One APB transfer; holds the request until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      error_cnt++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Block the remote input, release it, then time the restart
  task delay_run(input logic [7:0] dip, input logic [CNT_W-1:0] dly);
    dip_switch <= dip;
    remote_closed <= ~dip[0];
    cyc(10);
    check(motor_drive, 0);
    check(remote_halt_lamp, 1);
    remote_closed <= dip[0];
    wait_sig(0, 1'b1, n);
    check(n >= dly && n <= dly + 8, 1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {remote_closed, water_closed, overcurrent_det} = '0;
    {front_switch_on, power_in_ok} = 2'b11;
    dip_switch = 8'h00;
    cyc(6);
    presetn <= 1'b1;
    @(posedge pclk);
    check(screen_sel, SCREEN_SPLASH);
    check(remote_halt_lamp, 1);
    apb(1'b0, REG_CTRL, 32'h0);
    check({e, q[0]}, 2'b01);
    apb(1'b0, 8'h40, 32'h0);
    check(e, 1);
    check(power_lamp, 1);
    power_in_ok <= 1'b0;
    cyc(5);
    check(power_lamp, 0);
    power_in_ok <= 1'b1;
    wait_sig(0, 1'b1, n);
    check(run_lamp, 1);
    // Status shows motor on and permit granted while running
    apb(1'b0, REG_STATUS, 32'h0);
    check({e, q[2:0]}, 4'h3);
    for (int i = 0; i < 5; i++)
      delay_run(dips[i], dlys[i]);
    // Probe polarity with switch 2 off, then on
    dip_switch <= 8'h00;
    water_closed <= 1'b1;
    cyc(5);
    check(motor_drive, 0);
    check(remote_halt_lamp, 1);
    water_closed <= 1'b0;
    wait_sig(0, 1'b1, n);
    check(n >= BASE && n <= BASE + 8, 1);
    dip_switch <= 8'h02;
    cyc(5);
    check(motor_drive, 0);
    water_closed <= 1'b1;
    wait_sig(0, 1'b1, n);
    check(n <= BASE + 10, 1);
    dip_switch <= 8'h00;
    water_closed <= 1'b0;
    cyc(5);
    front_switch_on <= 1'b0;
    cyc(5);
    check(motor_drive, 0);
    front_switch_on <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h0);
    cyc(2);
    check(motor_drive, 0);
    apb(1'b1, REG_CTRL, 32'h1);
    wait_sig(0, 1'b1, n);
    // Over-current trip, hold, retry while still high, then recover
    overcurrent_det <= 1'b1;
    cyc(4);
    check(motor_drive, 0);
    cyc(1);
    check({error_lamp, screen_sel}, {1'b1, SCREEN_OC});
    wait_sig(1, 1'b0, n);
    check(n >= OCH - 4 && n <= OCH + 4, 1);
    wait_sig(1, 1'b1, n);
    check(n <= 3, 1);
    check(motor_drive, 0);
    overcurrent_det <= 1'b0;
    wait_sig(1, 1'b0, n);
    wait_sig(0, 1'b1, n);
    check(n <= 6, 1);
    // Start-up with freeze on, then cycling and freezing
    dip_switch <= 8'h40;
    presetn <= 1'b0;
    cyc(6);
    presetn <= 1'b1;
    cyc(60);
    check(screen_sel, SCREEN_SPLASH);
    dip_switch <= 8'h00;
    cyc(10);
    check(screen_sel <= SCREEN_LAST, 1);
    s = screen_sel;
    n = 0;
    while (screen_sel === s && n < 30)
    begin
      @(posedge pclk);
      n++;
    end
    check(screen_sel, (s == SCREEN_LAST) ? 3'h0 : s + 3'h1);
    dip_switch <= 8'h40;
    cyc(4);
    s = screen_sel;
    cyc(40);
    check(screen_sel, s);
    // The screen register must report the frozen screen as well
    apb(1'b0, REG_SCREEN, 32'h0);
    check({e, q[2:0]}, {1'b0, s});
    print_verdict();
  end

  // Cut a hang short well beyond the expected run length
  initial
  begin
    cyc(20000);
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
